// File: inc/irq_route_pkg.sv
/*
  constants, field layouts and carrier types for the board interrupt routing block.
  assumes one 100 MHz clock and an active-low asynchronous reset in every user but card_model, which has no reset.
*/
package irq_route_pkg;

  // ----------------------------------------
  // request line numbers
  // ----------------------------------------
  localparam int IRQ_TIMER0   = 0;
  localparam int IRQ_KEYBOARD = 1;
  localparam int IRQ_CASCADE  = 2;
  localparam int IRQ_SERIAL2  = 3;
  localparam int IRQ_SERIAL1  = 4;
  localparam int IRQ_FIXDISK  = 5;
  localparam int IRQ_FLOPPY   = 6;
  localparam int IRQ_PRINTER  = 7;
  localparam int IRQ_RTC      = 8;
  localparam int IRQ_VIDEO    = 9;
  localparam int IRQ_HDR_A    = 10;
  localparam int IRQ_HDR_B    = 11;
  localparam int IRQ_HDR_C    = 12;
  localparam int IRQ_COPROC   = 13;
  localparam int IRQ_HARDDISK = 14;
  localparam int IRQ_HDR_D    = 15;

  // ----------------------------------------
  // sizes, vector bases, reset values
  // ----------------------------------------
  localparam int         PIC_INPUTS   = 8;
  localparam int         AUX_WIDTH    = 16;
  localparam int         HDR_WIDTH    = 5;
  localparam logic [4:0] MASTER_BASE  = 5'h01;   // vectors 0x08..0x0f
  localparam logic [4:0] SLAVE_BASE   = 5'h0e;   // vectors 0x70..0x77
  localparam logic [2:0] CASCADE_PICK = 3'h2;
  localparam logic [7:0] PIC_RST      = 8'h00;
  localparam logic [7:0] VEC_RST      = 8'h00;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic intrq2_n;
    logic intrq1_n;
    logic intrq_n;
  } backplane_irq_t;

  typedef struct packed {
    logic disk_n;
    logic video_n;
  } front_irq_t;

  typedef struct packed {
    logic parity_err;
    logic timer0;
    logic keyboard;
    logic serial2;
    logic serial1;
    logic fixed_disk;
    logic floppy;
    logic printer;
    logic rtc;
    logic coproc;
  } onboard_irq_t;

  typedef struct packed {
    backplane_irq_t           bp;
    logic [HDR_WIDTH-1:0]     hdr_n;
    front_irq_t               front;
    logic [AUX_WIDTH-1:0]     aux_n;
  } pin_irq_t;

  // lowest set bit of a request vector, the highest priority
  function automatic logic [2:0] lowest_set(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // mask of all inputs with strictly higher priority than the lowest set bit
  function automatic logic [7:0] above_mask(input logic [7:0] v);
    logic [7:0] m;
    m = 8'hff;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        m = 8'((9'h001 << i) - 9'h001);
      end
    end
    return m;
  endfunction

endpackage

// File: src/pic_unit.sv
/*
  one eight-input prioritised, maskable, vectored interrupt controller.
  assumes requests are levels on clk, ack and eoi are one-cycle pulses from the cpu side.
*/
module pic_unit
  import irq_route_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // requests and control
  input  wire logic [7:0] req,
  input  wire logic [7:0] mask,
  input  wire logic       ack,
  input  wire logic       eoi,
  // status toward the cpu side
  output logic            int_req,
  output logic [2:0]      pick,
  output logic [7:0]      in_service
);

  logic [7:0] req_reg;
  logic [7:0] pend_reg;
  logic [7:0] isr_reg;
  logic [7:0] pend_next;
  logic [7:0] isr_next;

  // ----------------------------------------
  // priority decode
  // ----------------------------------------
  wire [7:0] rise      = req & ~req_reg;
  wire [7:0] eligible  = pend_reg & ~mask & above_mask(isr_reg);
  wire [7:0] pick_bit  = 8'(9'h001 << lowest_set(eligible));
  wire [7:0] eoi_bit   = 8'(9'h001 << lowest_set(isr_reg));

  assign pick       = lowest_set(eligible);
  assign int_req    = |eligible;
  assign in_service = isr_reg;

  // new edges win over the clear made by an acknowledge
  assign pend_next = (pend_reg & ~((ack && int_req) ? pick_bit : 8'h00)) | rise;
  assign isr_next  = (isr_reg & ~((eoi && |isr_reg) ? eoi_bit : 8'h00))
                   | ((ack && int_req) ? pick_bit : 8'h00);

  // ----------------------------------------
  // state
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_reg  <= PIC_RST;
      pend_reg <= PIC_RST;
      isr_reg  <= PIC_RST;
    end else begin
      req_reg  <= req;
      pend_reg <= pend_next;
      isr_reg  <= isr_next;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_ack_sets_isr : assert property (@(posedge clk) disable iff (!reset_n)
    ack && int_req |=> isr_reg[$past(pick)])
    else $error("acknowledged input not marked in service");

  a_mask_blocks_int : assert property (@(posedge clk) disable iff (!reset_n)
    (mask == 8'hff) |-> !int_req)
    else $error("interrupt raised with every input masked");

endmodule

// File: src/board_interrupt_routing.sv
/*
  routes backplane, header, front-plane, auxiliary and on-board requests onto sixteen
  request inputs of two cascaded controllers and answers cpu acknowledges with a vector.
  assumes pin inputs are asynchronous, on-board sources and cpu strobes are on clk.
*/
module board_interrupt_routing
  import irq_route_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // pins from outside
  input  wire pin_irq_t    pins,
  input  wire logic        aux_enable,
  // on-board sources
  input  wire onboard_irq_t onboard,
  // cpu side
  input  wire logic [15:0] irq_mask,
  input  wire logic        cpu_ack,
  input  wire logic        master_eoi,
  input  wire logic        slave_eoi,
  output logic             cpu_int,
  output logic             cpu_nmi,
  output logic [7:0]       vector,
  output logic             vector_valid,
  // backplane cascade address enable
  output logic             bp_cas_oe,
  // observation of the routed request lines
  output logic [15:0]      irq_lines
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  pin_irq_t   pin_s1_reg;
  pin_irq_t   pin_s2_reg;
  logic       aux_s1_reg;
  logic       aux_s2_reg;

  // two flops on every asynchronous pin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_reg <= '1;
      pin_s2_reg <= '1;
      aux_s1_reg <= 1'b0;
      aux_s2_reg <= 1'b0;
    end else begin
      pin_s1_reg <= pins;
      pin_s2_reg <= pin_s1_reg;
      aux_s1_reg <= aux_enable;
      aux_s2_reg <= aux_s1_reg;
    end
  end

  // ----------------------------------------
  // request routing
  // ----------------------------------------
  wire        bp_req0   = ~pin_s2_reg.bp.intrq_n;
  wire        bp_req1   = ~pin_s2_reg.bp.intrq1_n;
  wire        bp_req2   = ~pin_s2_reg.bp.intrq2_n;
  wire [4:0]  hdr_req   = ~pin_s2_reg.hdr_n;
  wire        fp_video  = ~pin_s2_reg.front.video_n;
  wire        fp_disk   = ~pin_s2_reg.front.disk_n;
  wire [15:0] aux_req   = aux_s2_reg ? ~pin_s2_reg.aux_n : 16'h0000;
  wire        small_sys = ~aux_s2_reg;
  wire        slave_int;
  logic [15:0] route;

  // fixed assignment of every source but parity_err to its request input, the third backplane line only in a small system
  always_comb begin
    route                = 16'h0000;
    route[IRQ_TIMER0]    = onboard.timer0;
    route[IRQ_KEYBOARD]  = onboard.keyboard;
    route[IRQ_CASCADE]   = slave_int;
    route[IRQ_SERIAL2]   = onboard.serial2;
    route[IRQ_SERIAL1]   = onboard.serial1;
    route[IRQ_FIXDISK]   = onboard.fixed_disk | bp_req0;
    route[IRQ_FLOPPY]    = onboard.floppy;
    route[IRQ_PRINTER]   = onboard.printer;
    route[IRQ_RTC]       = onboard.rtc;
    route[IRQ_VIDEO]     = fp_video | hdr_req[4] | (small_sys & bp_req2);
    route[IRQ_HDR_A]     = hdr_req[0] | bp_req1;
    route[IRQ_HDR_B]     = hdr_req[1];
    route[IRQ_HDR_C]     = hdr_req[2];
    route[IRQ_COPROC]    = onboard.coproc;
    route[IRQ_HARDDISK]  = fp_disk;
    route[IRQ_HDR_D]     = hdr_req[3];
  end

  // auxiliary bus lines add onto their own input numbers
  wire [15:0] req_all = route | aux_req;

  // ----------------------------------------
  // cascaded controllers
  // ----------------------------------------
  wire        master_int;
  wire [2:0]  master_pick;
  wire [2:0]  slave_pick;
  wire        to_slave  = (master_pick == CASCADE_PICK);
  wire        slave_ack = cpu_ack && master_int && to_slave;

  // master takes inputs 0-7, its input 2 is the slave's request
  pic_unit u_master (
    .clk        (clk),
    .reset_n    (reset_n),
    .req        (req_all[7:0]),
    .mask       (irq_mask[7:0]),
    .ack        (cpu_ack),
    .eoi        (master_eoi),
    .int_req    (master_int),
    .pick       (master_pick),
    .in_service ()
  );

  // slave takes inputs 8-15
  pic_unit u_slave (
    .clk        (clk),
    .reset_n    (reset_n),
    .req        (req_all[15:8]),
    .mask       (irq_mask[15:8]),
    .ack        (slave_ack),
    .eoi        (slave_eoi),
    .int_req    (slave_int),
    .pick       (slave_pick),
    .in_service ()
  );

  // vector supplied on board, never through a backplane cascade address
  wire [7:0] vec_next = to_slave ? {SLAVE_BASE, slave_pick} : {MASTER_BASE, master_pick};

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_int      <= 1'b0;
      cpu_nmi      <= 1'b0;
      vector       <= VEC_RST;
      vector_valid <= 1'b0;
      bp_cas_oe    <= 1'b0;
      irq_lines    <= 16'h0000;
    end else begin
      cpu_int      <= master_int;
      cpu_nmi      <= onboard.parity_err;
      vector_valid <= cpu_ack && master_int;
      if (cpu_ack && master_int) begin
        vector     <= vec_next;
      end
      bp_cas_oe    <= 1'b0;
      irq_lines    <= req_all;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_pin_low(logic p);
    $fell(p) ##1 !p;
  endsequence

  // one acknowledge that is not followed at once by another
  sequence s_lone_ack;
    (cpu_ack && master_int) ##1 !(cpu_ack && master_int);
  endsequence

  a_no_cascade_drive : assert property (!bp_cas_oe)
    else $error("cascade address driven onto backplane");

  a_bp_line_irq5 : assert property (
    s_pin_low(pins.bp.intrq_n) |-> ##2 irq_lines[IRQ_FIXDISK])
    else $error("backplane request did not reach input 5");

  a_bp_line_irq10 : assert property (
    s_pin_low(pins.bp.intrq1_n) |-> ##2 irq_lines[IRQ_HDR_A])
    else $error("backplane request did not reach input 10");

  a_header_irq15 : assert property (
    s_pin_low(pins.hdr_n[3]) |-> ##2 irq_lines[IRQ_HDR_D])
    else $error("header request did not reach input 15");

  a_header_irq11 : assert property (
    s_pin_low(pins.hdr_n[1]) |-> ##2 irq_lines[IRQ_HDR_B])
    else $error("header request did not reach input 11");

  a_header_irq12 : assert property (
    s_pin_low(pins.hdr_n[2]) |-> ##2 irq_lines[IRQ_HDR_C])
    else $error("header request did not reach input 12");

  a_video_irq9 : assert property (
    s_pin_low(pins.front.video_n) |-> ##2 irq_lines[IRQ_VIDEO])
    else $error("video request did not reach input 9");

  a_disk_irq14 : assert property (
    s_pin_low(pins.front.disk_n) |-> ##2 irq_lines[IRQ_HARDDISK])
    else $error("disk request did not reach input 14");

  // small system: the third backplane line carries the video request
  a_small_sys_irq9 : assert property (
    s_pin_low(pins.bp.intrq2_n) ##1 !aux_s2_reg |-> ##1 irq_lines[IRQ_VIDEO])
    else $error("backplane line did not reach input 9 in a small system");

  a_aux_bus_gate : assert property (
    (aux_s2_reg == 1'b0) ##1 (irq_lines[IRQ_FLOPPY] != onboard.floppy)
    |-> $past(onboard.floppy) != onboard.floppy)
    else $error("auxiliary bus drove a request while disabled");

  a_ack_vector : assert property (
    s_lone_ack |-> vector_valid ##1 !vector_valid)
    else $error("acknowledge not answered by a single vector pulse");

  a_slave_vector : assert property (
    cpu_ack && master_int && to_slave |=> vector[7:3] == SLAVE_BASE)
    else $error("cascade acknowledge did not give a slave vector");

  a_master_vector : assert property (
    cpu_ack && master_int && !to_slave |=> vector[7:3] == MASTER_BASE)
    else $error("master acknowledge did not give a master vector");

  a_vector_base : assert property (
    vector_valid |-> vector[7:3] == MASTER_BASE || vector[7:3] == SLAVE_BASE)
    else $error("vector outside both controller ranges");

  a_parity_nmi : assert property (onboard.parity_err |=> cpu_nmi)
    else $error("parity error did not raise nmi");

endmodule

// File: verification/card_model.sv
/*
  far-side cards and header sources driving the request pins.
  assumes the bench names active requests; pulled-up lines idle high.
*/
module card_model
  import irq_route_pkg::*;
(
  // clock
  input  wire logic        clk,
  // request selection, bit layout of pin_irq_t, 1 = asserting
  input  wire logic        slow,
  input  wire logic [25:0] want,
  // pins
  output pin_irq_t         pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // slow cards assert one cycle late
  // ----------------------------------------
  logic [25:0] late_reg;

  // delayed copy of the requests
  always_ff @(posedge clk) begin
    late_reg <= want;
  end

  // released lines are pulled high, active requests pull low
  assign pins = pin_irq_t'(~(slow ? late_reg : want));
endmodule

// File: verification/board_interrupt_routing_tb.sv
/*
  self-checking bench for the interrupt routing block.
  assumes the card model drives the pins; cpu strobes come from here.
*/
module board_interrupt_routing_tb
  import irq_route_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic         clk;
  logic         reset_n;
  logic         slow;
  logic [25:0]  want;
  pin_irq_t     pins;
  logic         aux_enable;
  onboard_irq_t onboard;
  logic [15:0]  irq_mask;
  logic         cpu_ack;
  logic         master_eoi;
  logic         slave_eoi;
  logic         cpu_int;
  logic         cpu_nmi;
  logic [7:0]   vector;
  logic         vector_valid;
  logic         bp_cas_oe;
  logic [15:0]  irq_lines;
  int           error_cnt;
  int           checks_done;
  int           a;
  int           b;
  int           vec_of_list[3] = '{5, 11, 0};

  card_model u_card_model (.clk(clk), .slow(slow), .want(want), .pins(pins));

  board_interrupt_routing u_board_interrupt_routing (
    .clk(clk), .reset_n(reset_n), .pins(pins), .aux_enable(aux_enable),
    .onboard(onboard), .irq_mask(irq_mask), .cpu_ack(cpu_ack),
    .master_eoi(master_eoi), .slave_eoi(slave_eoi), .cpu_int(cpu_int),
    .cpu_nmi(cpu_nmi), .vector(vector), .vector_valid(vector_valid),
    .bp_cas_oe(bp_cas_oe), .irq_lines(irq_lines));

  // ----------------------------------------
  // expectations
  // ----------------------------------------
  // routed request inputs, cascade input left out
  function automatic logic [15:0] exp_lines(logic [25:0] w, logic ae, onboard_irq_t o);
    logic [15:0] e;
    e = {w[21], w[17], o.coproc, w[20], w[19], w[18] | w[24],
         w[16] | w[22] | (!ae & w[25]), o.rtc, o.printer, o.floppy,
         o.fixed_disk | w[23], o.serial1, o.serial2, 1'b0, o.keyboard, o.timer0};
    if (ae) begin
      e = e | w[15:0];
    end
    return e & 16'hfffb;
  endfunction

  function automatic logic [7:0] vec_of(int i);
    return (i < 8) ? {MASTER_BASE, 3'(i)} : {SLAVE_BASE, 3'(i - 8)};
  endfunction

  // slave inputs rank at master input 2
  function automatic int key(int i);
    return (i < 8) ? i * 8 : 8 + i;
  endfunction

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask

  // wait for the request, acknowledge, check the one-cycle answer
  task automatic ack_expect(int i);
    int t;
    t = 0;
    while (cpu_int !== 1'b1 && t < 20) begin
      cyc(1);
      t++;
    end
    chk("cpu_int", 16'h1, {15'h0, cpu_int});
    chk("early_valid", 16'h0, {15'h0, vector_valid});
    cpu_ack = 1'b1;
    cyc(1);
    cpu_ack = 1'b0;
    chk("bp_cas_oe", 16'h0, {15'h0, bp_cas_oe});
    chk("vector_valid", 16'h1, {15'h0, vector_valid});
    chk("vector", {8'h0, vec_of(i)}, {8'h0, vector});
    master_eoi = 1'b1;
    slave_eoi  = (i >= 8);
    cyc(1);
    master_eoi = 1'b0;
    slave_eoi  = 1'b0;
    chk("valid_drop", 16'h0, {15'h0, vector_valid});
  endtask

  task automatic route(logic [25:0] w, logic ae, onboard_irq_t o);
    want       = w;
    aux_enable = ae;
    onboard    = o;
    cyc(5);
    chk("irq_lines", exp_lines(w, ae, o), irq_lines & 16'hfffb);
    chk("cpu_nmi", {15'h0, o.parity_err}, {15'h0, cpu_nmi});
    chk("bp_cas_oe", 16'h0, {15'h0, bp_cas_oe});
  endtask

  // ----------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200us;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    reset_n = 1'b0; slow = 1'b0; want = '0; aux_enable = 1'b0; onboard = '0;
    irq_mask = 16'h0; cpu_ack = 1'b0; master_eoi = 1'b0; slave_eoi = 1'b0;
    void'($urandom(68));
    cyc(3);
    reset_n = 1'b1;
    cyc(2);
    // acknowledge with nothing pending gives no answer
    cpu_ack = 1'b1;
    cyc(1);
    cpu_ack = 1'b0;
    chk("idle_ack", 16'h0, {15'h0, vector_valid});
    cyc(1);
    // every input except the cascade input 2 alone through the auxiliary bus
    aux_enable = 1'b1;
    cyc(3);
    for (int i = 0; i < 16; i++) begin
      if (i != 2) begin
        slow = 1'($urandom);
        want = 26'(1) << i;
        ack_expect(i);
        want = '0;
        cyc(3);
      end
    end
    // two requests together, the higher priority answers first
    for (int n = 0; n < 10; n++) begin
      a = $urandom % 16;
      b = (a + 1 + $urandom % 15) % 16;
      if (a != 2 && b != 2) begin
        want = (26'(1) << a) | (26'(1) << b);
        ack_expect(key(a) < key(b) ? a : b);
        ack_expect(key(a) < key(b) ? b : a);
        want = '0;
        cyc(3);
      end
    end
    // a masked request waits until unmasked
    foreach (vec_of_list[k]) begin
      irq_mask = 16'h1 << vec_of_list[k];
      want = 26'(1) << vec_of_list[k];
      cyc(8);
      chk("masked_int", 16'h0, {15'h0, cpu_int});
      irq_mask = 16'h0;
      ack_expect(vec_of_list[k]);
      want = '0;
      cyc(3);
    end
    // routing, one source at a time in both bus modes, then random mixes
    irq_mask = 16'hffff;
    for (int i = 0; i < 72; i++) begin
      route((i % 36 < 26) ? 26'(1) << (i % 36) : 26'h0, i >= 36,
            onboard_irq_t'((i % 36 >= 26) ? 10'(1) << (i % 36 - 26) : 10'h0));
    end
    for (int n = 0; n < 30; n++) begin
      slow = 1'($urandom);
      route(26'($urandom), 1'($urandom), onboard_irq_t'(10'($urandom)));
    end
    tally_and_finish();
  end

endmodule
